// ==== asc_pkg.sv ====
package asc_pkg;

  // Bus geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets.
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_CHSEL = 8'h04;
  localparam logic [7:0] OFF_RESULT = 8'h08;
  localparam logic [7:0] OFF_RESULT_HI = 8'h0C;
  localparam logic [7:0] OFF_PORT2 = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  // Mode register fields; bits 6, 2 and 1 are not stored.
  localparam int MODE_RUN_BIT = 7;
  localparam int MODE_FR_LSB = 3;
  localparam int MODE_FR_W = 3;
  localparam int MODE_CMP_BIT = 0;
  localparam logic [7:0] MODE_WMASK = 8'hB9;
  localparam logic [7:0] MODE_RST = 8'h00;

  // Channel select, result and pin control fields.
  localparam int CHSEL_W = 2;
  localparam logic [1:0] CHSEL_RST = 2'h0;
  localparam int RES_W = 10;
  localparam int RES_HI_LSB = 2;
  localparam int PINS = 4;
  localparam logic [3:0] PORT2_RST = 4'h0;

  // Status register fields.
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_READY_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing: clock period and comparator settle time.
  localparam int CLK_PERIOD_NS = 50;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_CYC = 8;
  localparam int BIT_CYC_BASE = 2;
  localparam int CNT_W = 10;

  // Converter sequencer states, Gray coded along idle-sample-convert.
  typedef enum logic [1:0] {
    ASC_IDLE = 2'b00,
    ASC_SAMPLE = 2'b01,
    ASC_CONVERT = 2'b11
  } asc_state_t;

endpackage : asc_pkg

// ==== asc_top.sv ====
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - Mode or channel select writes may leave the result undefined.
// - An analog-selected pin loses all of its digital functions.
// - Each conversion takes the time chosen by mode bits 5 to 3.
// - A result read meeting the update gets the old value first.
// - Mode or channel write at conversion end drops store and interrupt.
// - Each result carries ten bits of resolution.
// - Rewriting channel select leaves the done flag unchanged.
module asc_top #(
  parameter int SAMPLE_CYC = asc_pkg::SAMPLE_CYC,
  parameter int BIT_CYC_BASE = asc_pkg::BIT_CYC_BASE
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [asc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [asc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [asc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [asc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cmp_in,
  input wire logic [asc_pkg::PINS-1:0] port_in_raw,
  input wire logic [asc_pkg::PINS-1:0] port_oe_req,
  output logic [asc_pkg::PINS-1:0] port_in_gated,
  output logic [asc_pkg::PINS-1:0] port_oe_gated,
  output logic [asc_pkg::PINS-1:0] analog_pin_select_bits,
  output logic [asc_pkg::CHSEL_W-1:0] mux_sel,
  output logic [asc_pkg::RES_W-1:0] dac_code,
  output logic sample_en,
  output logic comparator_enable_bit,
  output logic conversion_done_irq
);

  ////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [7:0] converter_mode_reg_ff;
  logic [asc_pkg::CHSEL_W-1:0] channel_select_reg_ff;
  logic [asc_pkg::RES_W-1:0] result_reg_full_ff;
  logic [asc_pkg::PINS-1:0] port2_mode_control_reg_ff;
  logic conversion_done_flag_ff;
  logic [4:0] settle_cnt_ff;

  // Bus state.
  logic aw_have_ff;
  logic w_have_ff;
  logic [asc_pkg::ADDR_W-1:0] awaddr_ff;
  logic [7:0] wdata_ff;
  logic wlane_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [asc_pkg::DATA_W-1:0] rdata_ff;
  logic [1:0] rresp_ff;

  // Converter state.
  asc_pkg::asc_state_t state_ff;
  logic [asc_pkg::CNT_W-1:0] cnt_ff;
  logic [3:0] bit_idx_ff;
  logic [asc_pkg::RES_W-1:0] sar_ff;
  logic [asc_pkg::RES_W-1:0] pend_res_ff;
  logic pend_ff;
  logic irq_ff;
  logic sample_ff;
  logic [asc_pkg::PINS-1:0] pin_in_ff;
  logic [asc_pkg::PINS-1:0] pin_oe_ff;

  ////////////////////////////////////////////////////////////////////////
  // Decode of the write that executes this cycle.
  logic wr_go;
  logic wr_mode;
  logic wr_chsel;
  logic wr_port2;
  logic wr_status;
  logic wr_hit;
  logic restart;
  assign wr_go = aw_have_ff & w_have_ff & ~bvalid_ff;
  assign wr_mode = wr_go & wlane_ff
    & (awaddr_ff[7:2] == asc_pkg::OFF_MODE[7:2]);
  assign wr_chsel = wr_go & wlane_ff
    & (awaddr_ff[7:2] == asc_pkg::OFF_CHSEL[7:2]);
  assign wr_port2 = wr_go & wlane_ff
    & (awaddr_ff[7:2] == asc_pkg::OFF_PORT2[7:2]);
  assign wr_status = wr_go & wlane_ff
    & (awaddr_ff[7:2] == asc_pkg::OFF_STATUS[7:2]);
  assign wr_hit = (awaddr_ff[7:2] <= asc_pkg::OFF_STATUS[7:2]);
  // A mode or channel write aborts and restarts the running conversion.
  assign restart = wr_mode | wr_chsel;

  // Read decode at the address handshake.
  logic ar_go;
  logic rd_result;
  logic rd_hit;
  logic [asc_pkg::DATA_W-1:0] rd_val;
  assign ar_go = s_axi_arvalid & arready_ff;
  assign rd_result = ar_go
    & ((s_axi_araddr[7:2] == asc_pkg::OFF_RESULT[7:2])
    | (s_axi_araddr[7:2] == asc_pkg::OFF_RESULT_HI[7:2]));
  assign rd_hit = (s_axi_araddr[7:2] <= asc_pkg::OFF_STATUS[7:2]);

  // Read multiplexer; unused upper bits read as zero.
  always_comb begin
    rd_val = '0;
    unique case (s_axi_araddr[7:2])
      asc_pkg::OFF_MODE[7:2]: rd_val[7:0] = converter_mode_reg_ff;
      asc_pkg::OFF_CHSEL[7:2]: rd_val[1:0] = channel_select_reg_ff;
      asc_pkg::OFF_RESULT[7:2]: rd_val[9:0] = result_reg_full_ff;
      asc_pkg::OFF_RESULT_HI[7:2]:
        rd_val[7:0] = result_reg_full_ff[9:asc_pkg::RES_HI_LSB];
      asc_pkg::OFF_PORT2[7:2]: rd_val[3:0] = port2_mode_control_reg_ff;
      asc_pkg::OFF_STATUS[7:2]: begin
        rd_val[asc_pkg::STAT_DONE_BIT] = conversion_done_flag_ff;
        rd_val[asc_pkg::STAT_READY_BIT] =
          (settle_cnt_ff == 5'(asc_pkg::SETTLE_CYC));
        rd_val[asc_pkg::STAT_BUSY_BIT] = (state_ff != asc_pkg::ASC_IDLE);
      end
      default: rd_val = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Write channels: address and data are taken in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      awaddr_ff <= '0;
      wdata_ff <= 8'h00;
      wlane_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= asc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        aw_have_ff <= 1'b1;
        awready_ff <= 1'b0;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_ff) begin
        w_have_ff <= 1'b1;
        wready_ff <= 1'b0;
        wdata_ff <= s_axi_wdata[7:0];
        wlane_ff <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? asc_pkg::RESP_OKAY : asc_pkg::RESP_SLVERR;
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // Read channel: data is captured at the address edge, one beat later.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= asc_pkg::RESP_OKAY;
    end else if (ar_go) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_val;
      rresp_ff <= rd_hit ? asc_pkg::RESP_OKAY : asc_pkg::RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Software-written control registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      converter_mode_reg_ff <= asc_pkg::MODE_RST;
      channel_select_reg_ff <= asc_pkg::CHSEL_RST;
      port2_mode_control_reg_ff <= asc_pkg::PORT2_RST;
    end else begin
      if (wr_mode) begin
        converter_mode_reg_ff <= wdata_ff & asc_pkg::MODE_WMASK;
      end
      // Only the channel field is kept; upper bits are expected zero.
      if (wr_chsel) begin
        channel_select_reg_ff <= wdata_ff[asc_pkg::CHSEL_W-1:0];
      end
      if (wr_port2) begin
        port2_mode_control_reg_ff <= wdata_ff[asc_pkg::PINS-1:0];
      end
    end
  end

  // Comparator settle timer; status shows when the start-up delay is met.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_cnt_ff <= 5'h00;
    end else if (!converter_mode_reg_ff[asc_pkg::MODE_CMP_BIT]) begin
      settle_cnt_ff <= 5'h00;
    end else if (settle_cnt_ff != 5'(asc_pkg::SETTLE_CYC)) begin
      settle_cnt_ff <= settle_cnt_ff + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Converter sequencer.
  logic run;
  logic [asc_pkg::MODE_FR_W-1:0] fr;
  logic [asc_pkg::CNT_W-1:0] bit_cyc;
  logic [asc_pkg::RES_W-1:0] bit_mask;
  logic [asc_pkg::RES_W-1:0] sar_keep;
  logic eoc;
  assign run = converter_mode_reg_ff[asc_pkg::MODE_RUN_BIT];
  assign fr =
    converter_mode_reg_ff[asc_pkg::MODE_FR_LSB +: asc_pkg::MODE_FR_W];
  assign bit_cyc = asc_pkg::CNT_W'(BIT_CYC_BASE << fr);
  assign bit_mask = asc_pkg::RES_W'(10'h001 << bit_idx_ff);
  // A trial bit stays set when the comparator finds the input above it.
  assign sar_keep = cmp_in ? sar_ff : (sar_ff & ~bit_mask);
  assign eoc = (state_ff == asc_pkg::ASC_CONVERT) && (cnt_ff == '0)
    && (bit_idx_ff == 4'h0);

  // Conversions repeat back to back while the run bit is set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= asc_pkg::ASC_IDLE;
      cnt_ff <= '0;
      bit_idx_ff <= 4'h0;
      sar_ff <= '0;
      sample_ff <= 1'b0;
    end else if (restart || !run) begin
      state_ff <= asc_pkg::ASC_IDLE;
      sample_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        asc_pkg::ASC_IDLE: begin
          state_ff <= asc_pkg::ASC_SAMPLE;
          cnt_ff <= asc_pkg::CNT_W'(SAMPLE_CYC - 1);
          sample_ff <= 1'b1;
        end
        asc_pkg::ASC_SAMPLE: begin
          if (cnt_ff == '0) begin
            state_ff <= asc_pkg::ASC_CONVERT;
            sample_ff <= 1'b0;
            bit_idx_ff <= 4'(asc_pkg::RES_W - 1);
            sar_ff <= 10'h200;
            cnt_ff <= bit_cyc - 1'b1;
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        asc_pkg::ASC_CONVERT: begin
          if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
          end else if (bit_idx_ff == 4'h0) begin
            sar_ff <= sar_keep;
            state_ff <= asc_pkg::ASC_SAMPLE;
            cnt_ff <= asc_pkg::CNT_W'(SAMPLE_CYC - 1);
            sample_ff <= 1'b1;
          end else begin
            sar_ff <= sar_keep | (bit_mask >> 1);
            bit_idx_ff <= bit_idx_ff - 4'h1;
            cnt_ff <= bit_cyc - 1'b1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result store, done flag and interrupt pulse.
  logic store_now;
  logic store_go;
  logic [asc_pkg::RES_W-1:0] store_val;
  assign store_now = eoc & ~restart;
  assign store_go = (store_now & ~rd_result) | pend_ff;
  assign store_val = pend_ff ? pend_res_ff : sar_keep;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_ff <= 1'b0;
      pend_res_ff <= '0;
      result_reg_full_ff <= '0;
    end else begin
      pend_ff <= store_now & rd_result;
      if (store_now && rd_result) begin
        pend_res_ff <= sar_keep;
      end
      if (store_go) begin
        result_reg_full_ff <= store_val;
      end
    end
  end

  // Hardware set beats a software clear landing in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conversion_done_flag_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= store_go;
      if (store_go) begin
        conversion_done_flag_ff <= 1'b1;
      end else if (wr_status && wdata_ff[asc_pkg::STAT_DONE_BIT]) begin
        conversion_done_flag_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Analog pins lose digital use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_in_ff <= '0;
      pin_oe_ff <= '0;
    end else begin
      pin_in_ff <= port_in_raw & ~port2_mode_control_reg_ff;
      pin_oe_ff <= port_oe_req & ~port2_mode_control_reg_ff;
    end
  end

  // Outputs, each taken straight from a flip-flop.
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign port_in_gated = pin_in_ff;
  assign port_oe_gated = pin_oe_ff;
  assign analog_pin_select_bits = port2_mode_control_reg_ff;
  assign mux_sel = channel_select_reg_ff;
  assign dac_code = sar_ff;
  assign sample_en = sample_ff;
  assign comparator_enable_bit = converter_mode_reg_ff[asc_pkg::MODE_CMP_BIT];
  assign conversion_done_irq = irq_ff;

endmodule : asc_top

// ==== asc_top_sva.sv ====
`timescale 1ns/1ps
module asc_top_chk #(
  parameter int SAMPLE_CYC = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [3:0] port_in_raw,
  input wire logic [3:0] port_oe_req,
  input wire logic [3:0] port_in_gated,
  input wire logic [3:0] port_oe_gated,
  input wire logic [3:0] analog_pin_select_bits,
  input wire logic sample_en,
  input wire logic conversion_done_irq
);
  logic [7:0] wa_ff;
  logic [7:0] scnt_ff;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////
  // Last write address and length of the current sampling phase.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wa_ff <= 8'h00;
      scnt_ff <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wa_ff <= s_axi_awaddr;
      scnt_ff <= sample_en ? scnt_ff + 8'h01 : 8'h00;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  property p_pin_in;
    $past(aresetn) |->
      port_in_gated == $past(port_in_raw & ~analog_pin_select_bits);
  endproperty
  a_pin_in: assert property (p_pin_in)
    else $error("Analog pin still passes digital input.");
  property p_pin_oe;
    $past(aresetn) |->
      port_oe_gated == $past(port_oe_req & ~analog_pin_select_bits);
  endproperty
  a_pin_oe: assert property (p_pin_oe)
    else $error("Analog pin still drives digital output.");
  property p_samp_len;
    sample_en |-> scnt_ff < SAMPLE_CYC;
  endproperty
  a_samp_len: assert property (p_samp_len)
    else $error("Sampling phase runs too long.");
  property p_conv_min;
    $fell(sample_en) |=> !conversion_done_irq [*8];
  endproperty
  a_conv_min: assert property (p_conv_min)
    else $error("Conversion ended too early.");
  property p_irq_pulse;
    conversion_done_irq |=> !conversion_done_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("Completion pulse longer than one cycle.");
  property p_irq_samp;
    $rose(conversion_done_irq) |-> sample_en;
  endproperty
  a_irq_samp: assert property (p_irq_samp)
    else $error("Completion without restart of sampling.");
  // A store on the write edge would show up as an irq when bvalid is seen.
  property p_wr_no_irq;
    $rose(s_axi_bvalid) && wa_ff[7:3] == 5'h00 |-> !conversion_done_irq;
  endproperty
  a_wr_no_irq: assert property (p_wr_no_irq)
    else $error("Completion raised despite mode or channel write.");
  property p_rd_no_irq;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:3] == 5'h01 |->
      ##1 !$rose(conversion_done_irq);
  endproperty
  a_rd_no_irq: assert property (p_rd_no_irq)
    else $error("Result stored on the edge of its read.");
endmodule : asc_top_chk

bind asc_top asc_top_chk #(.SAMPLE_CYC(SAMPLE_CYC)) asc_top_chk_i (.*);

// ==== asc_top_bench.sv ====
`timescale 1ns/1ps
module asc_top_bench;
  localparam int S_CYC = 2;
  localparam int B_CYC = 2;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cmp_in = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, sample_en, comparator_enable_bit, conversion_done_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, mux_sel;
  logic [3:0] port_in_raw = 4'h0, port_oe_req = 4'h0;
  logic [3:0] port_in_gated, port_oe_gated, analog_pin_select_bits;
  logic [9:0] dac_code, vin = 10'h0;
  logic [15:0] rnd = 16'h0006;
  int mismatches = 0;
  int total_checks = 0;
  asc_top #(.SAMPLE_CYC(S_CYC), .BIT_CYC_BASE(B_CYC)) asc_top_i (.*);
  ////////////////////////////////////////////////////////////////////////
  // Clock, and a comparator that sees the trial code one cycle late.
  always #25 aclk = ~aclk;
  always @(posedge aclk) cmp_in <= (vin >= dac_code);
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic int conv_cyc(input int fr);
    return S_CYC + 10 * (B_CYC << fr);
  endfunction : conv_cyc
  function automatic logic [7:0] gate(input logic [3:0] a, logic [15:0] v);
    return {v[7:4] & ~a, v[11:8] & ~a};
  endfunction : gate
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  // Each transfer starts one edge after the last, so no signal is driven
  // twice in one time step.
  task automatic wr(input logic [7:0] a, logic [31:0] d, logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, er);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd
  ////////////////////////////////////////////////////////////////////////
  // Watchdog sized well above the longest conversion sweep.
  initial begin
    repeat (30000) @(posedge aclk);
    mismatches++;
    stop_test();
  end
  // Main sequence.
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [3:0] sel;
    int n;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(8'(i * 4), d, r);
      check(d, 32'h0);
    end
    wr(8'h18, 32'hFF, asc_pkg::RESP_SLVERR);
    rd(8'h18, d, r);
    check({30'h0, r}, {30'h0, asc_pkg::RESP_SLVERR});
    check(d, 32'h0);
    // Pin gating with random levels, all pins analog first.
    // this block has no pull-up option to clear.
    // pins stay fixed during conversions; no halt mode here.
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      sel = (i == 0) ? 4'hF : rnd[3:0];
      wr(asc_pkg::OFF_PORT2, {28'h0, sel}, asc_pkg::RESP_OKAY);
      port_in_raw <= rnd[7:4];
      port_oe_req <= rnd[11:8];
      repeat (2) @(posedge aclk);
      check({28'h0, analog_pin_select_bits}, {28'h0, sel});
      check({port_in_gated, port_oe_gated}, gate(sel, rnd));
    end
    // One conversion for every time setting, then abort and read back.
    for (int fr = 0; fr < 8; fr++) begin
      rnd = lfsr(rnd);
      vin <= rnd[9:0];
      wr(asc_pkg::OFF_CHSEL, {30'h0, rnd[11:10]}, asc_pkg::RESP_OKAY);
      wr(asc_pkg::OFF_MODE, 32'(fr << 3) | 32'h01, asc_pkg::RESP_OKAY);
      // settle before the run bit; step one comes first.
      repeat (20) @(posedge aclk);
      wr(asc_pkg::OFF_STATUS, 32'h01, asc_pkg::RESP_OKAY);
      wr(asc_pkg::OFF_MODE, 32'(fr << 3) | 32'h81, asc_pkg::RESP_OKAY);
      check({31'h0, comparator_enable_bit}, 32'h1);
      n = 0;
      while (sample_en !== 1'b1) @(posedge aclk);
      while (conversion_done_irq !== 1'b1) begin
        @(posedge aclk);
        n++;
      end
      check(n, conv_cyc(fr));
      // result fetched before any mode or channel write.
      rd(asc_pkg::OFF_RESULT, d, r);
      check(d, {22'h0, vin});
      rd(asc_pkg::OFF_RESULT_HI, d, r);
      check(d, {24'h0, vin[9:2]});
      wr(asc_pkg::OFF_CHSEL, {30'h0, ~rnd[11:10]}, asc_pkg::RESP_OKAY);
      check({30'h0, mux_sel}, {30'h0, ~rnd[11:10]});
      rd(asc_pkg::OFF_STATUS, d, r);
      check({31'h0, d[0]}, 32'h1);
      wr(asc_pkg::OFF_MODE, 32'h0, asc_pkg::RESP_OKAY);
      rd(asc_pkg::OFF_RESULT, d, r);
      check(d, {22'h0, vin});
    end
    stop_test();
  end
endmodule : asc_top_bench
